/* card_regs_checker_asserts.sv */
`timescale 1ns/10ps
module card_regs_checker (
  input wire       clk_sys_in,
  input wire       reset_n_in,
  input wire       reg_sel_in,
  input wire       reg_wr_in,
  input wire       reg_rd_in,
  input wire [7:0] reg_wdata_in,
  input wire       voltage_fault_in,
  input wire       current_fault_in,
  input wire [7:0] reg_rdata_out,
  input wire       card_present_level_out,
  input wire       converter_enable_out,
  input wire       supply_1v8_out,
  input wire       supply_3v_out,
  input wire       supply_5v_out,
  input wire       card_deactivate_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);
  wire st_wr = reg_wr_in && !reg_sel_in;
  wire any_on = supply_1v8_out || supply_3v_out || supply_5v_out;
  ////////////////////////////////////////////////////////////////
  property p_five;
    st_wr && reg_wdata_in[1:0] == 2'h3 ##1 !reg_wr_in |=> supply_5v_out;
  endproperty
  a_five: assert property (p_five) else $error("5V select not decoded");
  property p_start;
    st_wr && reg_wdata_in[1:0] != 2'h0 && card_present_level_out |=> converter_enable_out;
  endproperty
  a_start: assert property (p_start) else $error("converter not started");
  property p_stop;
    st_wr && reg_wdata_in[1:0] == 2'h0 |=> !converter_enable_out;
  endproperty
  a_stop: assert property (p_stop) else $error("converter not stopped");
  property p_deact;
    st_wr && reg_wdata_in[2] |-> ##[1:2] card_deactivate_out;
  endproperty
  a_deact: assert property (p_deact) else $error("test fault did not deactivate");
  // Faults excluded, they may deactivate legally
  property p_keep;
    st_wr && reg_wdata_in[3:2] == 2'h0 && reg_wdata_in[1:0] != 2'h0 && any_on
      && !voltage_fault_in && !current_fault_in |=> !card_deactivate_out [*3];
  endproperty
  a_keep: assert property (p_keep) else $error("deactivation on supply change");
  property p_swset;
    st_wr && reg_wdata_in[4] ##[1:3] (reg_rd_in && !reg_sel_in) |=> reg_rdata_out[4];
  endproperty
  a_swset: assert property (p_swset) else $error("written change flag lost");
  property p_layout;
    reg_rd_in && !reg_sel_in |=> reg_rdata_out[7:5] == 3'h4;
  endproperty
  a_layout: assert property (p_layout) else $error("status top bits wrong");
  property p_reset;
    $rose(reset_n_in) |-> !converter_enable_out && !any_on;
  endproperty
  a_reset: assert property (p_reset) else $error("supply on after reset");
endmodule

bind card_status_voltage_regs card_regs_checker chk_i (.*);

/* card_status_voltage_map.vh */
`ifndef CARD_STATUS_VOLTAGE_MAP_VH
`define CARD_STATUS_VOLTAGE_MAP_VH

// Register selects on the register port
`define STATUS_BYTE_SEL      1'b0
`define CONTROL_BYTE_SEL     1'b1

// Status and voltage byte fields
`define STATUS_TOP_HI        7
`define STATUS_TOP_LO        6
`define STATUS_TOP_VALUE     2'h2
`define STATUS_ANSWER_ERR    5
`define STATUS_CHANGE        4
`define STATUS_CURRENT_ERR   3
`define STATUS_VOLTAGE_ERR   2
`define SUPPLY_SEL_HI        1
`define SUPPLY_SEL_LO        0

// Supply select codes
`define SUPPLY_OFF           2'h0
`define SUPPLY_1V8           2'h1
`define SUPPLY_3V            2'h2
`define SUPPLY_5V            2'h3
`define SUPPLY_RESET         2'h0

// Control and detect byte fields
`define CONTROL_RESERVED     7
`define CONTROL_AUTO_RESET   6
`define CONTROL_SHUTDOWN     5
`define CONTROL_POLARITY     4
`define CONTROL_PULLUP       3
`define FILTER_SEL_HI        2
`define FILTER_SEL_LO        0
`define CONTROL_RESET        7'h0A

// Flag reset value
`define FLAG_RESET           1'b0

// Settle time of the pin synchroniser before the power-up look
`define STARTUP_CYCLES       2'h3

`endif

/* card_status_voltage_regs.v */
// Operation
// - Card-change flag sets on each filtered presence change, insertion or extraction.
// - After power-up, presence pin at 0 sets the card-change flag.
// - Software writing one sets any of the three error/change flags.
// - Reading the status byte clears the three flags; writing zero does not.
// - Voltage-error flag sets when supply leaves the selected range.
// - Software-set voltage-error flag deactivates the card like a real fault.
// - Supply select decodes 00 off, 01 1.8V, 10 3V, 11 5V.
// - Nonzero supply write starts the converter only with a card present.
// - Zero supply write stops the converter.
// - No deactivation when switching between nonzero supply values.
// - Supply select resets to 00, no card supply.
// - Card-change and voltage-error flags reset to 0.
// - Presence pin filtered: accepted after 0, 4, 8 ... 256 identical samples.
`timescale 1ns/10ps
module card_status_voltage_regs #(
  parameter FILTER_CNT_W = 9
) (
  input  wire       clk_sys_in,
  input  wire       reset_n_in,
  input  wire       reg_sel_in,
  input  wire       reg_wr_in,
  input  wire       reg_rd_in,
  input  wire [7:0] reg_wdata_in,
  input  wire       presence_detect_pin_in,
  input  wire       current_fault_in,
  input  wire       voltage_fault_in,
  input  wire       converter_mode_bit_in,
  output reg  [7:0] reg_rdata_out,
  output reg        card_present_level_out,
  output reg        converter_enable_out,
  output reg        regulator_mode_out,
  output reg        supply_1v8_out,
  output reg        supply_3v_out,
  output reg        supply_5v_out,
  output reg        card_deactivate_out,
  output reg        auto_card_reset_enable_out,
  output reg        shutdown_out,
  output reg        pullup_enable_out
);

`include "card_status_voltage_map.vh"

  ////////////////////////////////////////////////////////////////////////
  // Register state
  reg  [1:0] card_supply_select_q;
  reg  [6:0] control_q;
  reg  [1:0] startup_q;
  reg        startup_done_q;
  reg  [2:0] current_sync_q;
  reg  [2:0] voltage_sync_q;
  reg        current_level_q;
  reg        voltage_level_q;

  wire       status_wr;
  wire       status_rd;
  wire       control_wr;
  wire [2:0] presence_filter_select;
  wire       presence_polarity_select;
  wire       pin_sample;
  wire       pin_sample_ok;
  wire       pin_filtered;
  wire       pin_change;
  wire       current_event;
  wire       voltage_event;
  wire       change_set;
  wire       current_set;
  wire       voltage_set;
  wire       card_change_flag;
  wire       card_current_error_flag;
  wire       card_voltage_error_flag;
  wire       polarity_changed;
  wire       power_up_absent;
  wire [1:0] new_select;
  wire [7:0] status_byte;
  wire [7:0] control_byte;
  wire       card_present_level;

  assign status_wr  = reg_wr_in && (reg_sel_in == `STATUS_BYTE_SEL);
  assign status_rd  = reg_rd_in && (reg_sel_in == `STATUS_BYTE_SEL);
  assign control_wr = reg_wr_in && (reg_sel_in == `CONTROL_BYTE_SEL);

  assign presence_filter_select   = control_q[`FILTER_SEL_HI:`FILTER_SEL_LO];
  assign presence_polarity_select = control_q[`CONTROL_POLARITY];

  ////////////////////////////////////////////////////////////////////////
  // Presence pin synchroniser and filter
  presence_filter #(
    .CNT_W         (FILTER_CNT_W)
  ) u_presence_filter (
    .clk_sys_in    (clk_sys_in),
    .reset_n_in    (reset_n_in),
    .pin_in        (presence_detect_pin_in),
    .filter_sel_in (presence_filter_select),
    .sample_out    (pin_sample),
    .sample_ok_out (pin_sample_ok),
    .level_out     (pin_filtered),
    .change_out    (pin_change)
  );

  // Polarity set: closed detector pulls low without card
  assign card_present_level = presence_polarity_select ? pin_filtered : ~pin_filtered;

  ////////////////////////////////////////////////////////////////////////
  // Power-up look at the pin, once the synchroniser has settled
  always @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      startup_q      <= 2'h0;
      startup_done_q <= 1'b0;
    end else if (!startup_done_q) begin
      if (startup_q == `STARTUP_CYCLES) begin
        if (pin_sample_ok) begin
          startup_done_q <= 1'b1;
        end
      end else begin
        startup_q <= startup_q + 2'h1;
      end
    end
  end

  assign power_up_absent = !startup_done_q && (startup_q == `STARTUP_CYCLES) &&
                           pin_sample_ok && !pin_sample;

  ////////////////////////////////////////////////////////////////////////
  // Fault inputs come from the analogue side, so they are resynchronised
  always @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      current_sync_q  <= 3'h0;
      voltage_sync_q  <= 3'h0;
      current_level_q <= 1'b0;
      voltage_level_q <= 1'b0;
    end else begin
      current_sync_q <= {current_sync_q[1:0], current_fault_in};
      voltage_sync_q <= {voltage_sync_q[1:0], voltage_fault_in};
      if (current_sync_q[1] == current_sync_q[2]) begin
        current_level_q <= current_sync_q[2];
      end
      if (voltage_sync_q[1] == voltage_sync_q[2]) begin
        voltage_level_q <= voltage_sync_q[2];
      end
    end
  end

  // Edge only, so a fault that persists is not re-flagged after every read
  assign current_event = (current_sync_q[1] == current_sync_q[2]) &&
                         current_sync_q[2] && !current_level_q;
  assign voltage_event = (voltage_sync_q[1] == voltage_sync_q[2]) &&
                         voltage_sync_q[2] && !voltage_level_q &&
                         (card_supply_select_q != `SUPPLY_OFF);

  ////////////////////////////////////////////////////////////////////////
  // Sticky flags
  assign polarity_changed = control_wr &&
                            (reg_wdata_in[`CONTROL_POLARITY] != presence_polarity_select);

  assign change_set  = pin_change || power_up_absent || polarity_changed ||
                       (status_wr && reg_wdata_in[`STATUS_CHANGE]);
  assign current_set = current_event ||
                       (status_wr && reg_wdata_in[`STATUS_CURRENT_ERR]);
  assign voltage_set = voltage_event ||
                       (status_wr && reg_wdata_in[`STATUS_VOLTAGE_ERR]);

  sticky_flag u_change_flag (
    .clk_sys_in (clk_sys_in),
    .reset_n_in (reset_n_in),
    .set_in     (change_set),
    .clear_in   (status_rd),
    .flag_out   (card_change_flag)
  );

  sticky_flag u_current_flag (
    .clk_sys_in (clk_sys_in),
    .reset_n_in (reset_n_in),
    .set_in     (current_set),
    .clear_in   (status_rd),
    .flag_out   (card_current_error_flag)
  );

  sticky_flag u_voltage_flag (
    .clk_sys_in (clk_sys_in),
    .reset_n_in (reset_n_in),
    .set_in     (voltage_set),
    .clear_in   (status_rd),
    .flag_out   (card_voltage_error_flag)
  );

  ////////////////////////////////////////////////////////////////////////
  // Writable fields
  assign new_select = reg_wdata_in[`SUPPLY_SEL_HI:`SUPPLY_SEL_LO];

  always @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      card_supply_select_q <= `SUPPLY_RESET;
      control_q            <= `CONTROL_RESET;
      converter_enable_out <= 1'b0;
    end else begin
      if (status_wr) begin
        card_supply_select_q <= new_select;
        if (new_select == `SUPPLY_OFF) begin
          converter_enable_out <= 1'b0;
        end else if (card_present_level) begin
          converter_enable_out <= 1'b1;
        end
      end
      if (control_wr) begin
        control_q <= reg_wdata_in[6:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Supply decode and deactivation
  always @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      supply_1v8_out      <= 1'b0;
      supply_3v_out       <= 1'b0;
      supply_5v_out       <= 1'b0;
      regulator_mode_out  <= 1'b0;
      card_deactivate_out <= 1'b0;
    end else begin
      supply_1v8_out     <= (card_supply_select_q == `SUPPLY_1V8);
      supply_3v_out      <= (card_supply_select_q == `SUPPLY_3V);
      supply_5v_out      <= (card_supply_select_q == `SUPPLY_5V);
      regulator_mode_out <= (card_supply_select_q == `SUPPLY_1V8) && converter_mode_bit_in;
      card_deactivate_out <= voltage_set || current_set;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read path and mirrored control outputs
  assign status_byte  = {`STATUS_TOP_VALUE, 1'b0, card_change_flag,
                         card_current_error_flag, card_voltage_error_flag,
                         card_supply_select_q};
  assign control_byte = {1'b0, control_q};

  always @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      reg_rdata_out              <= 8'h00;
      card_present_level_out     <= 1'b0;
      auto_card_reset_enable_out <= 1'b0;
      shutdown_out               <= 1'b0;
      pullup_enable_out          <= 1'b0;
    end else begin
      if (reg_rd_in) begin
        reg_rdata_out <= (reg_sel_in == `STATUS_BYTE_SEL) ? status_byte : control_byte;
      end
      card_present_level_out     <= card_present_level;
      auto_card_reset_enable_out <= control_q[`CONTROL_AUTO_RESET];
      shutdown_out               <= control_q[`CONTROL_SHUTDOWN];
      pullup_enable_out          <= control_q[`CONTROL_PULLUP];
    end
  end

endmodule

/* host_model.sv */
`timescale 1ns/10ps
module host_model (
  input  wire       clk_in,
  input  wire [7:0] rdata_in,
  output reg        sel_out,
  output reg        wr_out,
  output reg        rd_out,
  output reg  [7:0] wdata_out
);
  initial begin
    sel_out = 1'b0;
    wr_out = 1'b0;
    rd_out = 1'b0;
    wdata_out = 8'h00;
  end
  ////////////////////////////////////////////////////////////////
  task wr(input logic s, input logic [7:0] d);
    begin
      @(negedge clk_in);
      sel_out <= s;
      wdata_out <= s ? {1'b0, d[6:0]} : d;
      wr_out <= 1'b1;
      @(negedge clk_in);
      wr_out <= 1'b0;
      // Stale data would hide a missed strobe
      wdata_out <= ~d;
      @(negedge clk_in);
    end
  endtask
  task rd(input logic s, output logic [7:0] q);
    begin
      @(negedge clk_in);
      sel_out <= s;
      rd_out <= 1'b1;
      @(negedge clk_in);
      rd_out <= 1'b0;
      q = rdata_in;
    end
  endtask
endmodule

/* presence_filter.v */
`timescale 1ns/10ps
module presence_filter #(
  parameter CNT_W = 9
) (
  input  wire       clk_sys_in,
  input  wire       reset_n_in,
  input  wire       pin_in,
  input  wire [2:0] filter_sel_in,
  output wire       sample_out,
  output wire       sample_ok_out,
  output reg        level_out,
  output reg        change_out
);

  reg  [2:0]       sync_q;
  reg  [CNT_W-1:0] count_q;
  wire [CNT_W-1:0] need;
  wire [CNT_W-1:0] count_inc;

  // Three stages; only the later two are compared
  always @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sync_q <= 3'h7;
    end else begin
      sync_q <= {sync_q[1:0], pin_in};
    end
  end

  assign sample_out    = sync_q[2];
  assign sample_ok_out = (sync_q[1] == sync_q[2]);
  assign need          = {{(CNT_W-1){1'b0}}, 1'b1} << ({1'b0, filter_sel_in} + 4'h1);
  assign count_inc     = count_q + {{(CNT_W-1){1'b0}}, 1'b1};

  ////////////////////////////////////////////////////////////////////////
  // Identical sample count
  always @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      count_q    <= {CNT_W{1'b0}};
      level_out  <= 1'b1;
      change_out <= 1'b0;
    end else begin
      change_out <= 1'b0;
      if (!sample_ok_out || (sync_q[2] == level_out)) begin
        count_q <= {CNT_W{1'b0}};
      end else if (filter_sel_in == 3'h0 || count_inc >= need) begin
        count_q    <= {CNT_W{1'b0}};
        level_out  <= sync_q[2];
        change_out <= 1'b1;
      end else begin
        count_q <= count_inc;
      end
    end
  end

endmodule

/* sticky_flag.v */
`timescale 1ns/10ps
module sticky_flag (
  input  wire clk_sys_in,
  input  wire reset_n_in,
  input  wire set_in,
  input  wire clear_in,
  output reg  flag_out
);

`include "card_status_voltage_map.vh"

  always @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      flag_out <= `FLAG_RESET;
    end else if (set_in) begin
      flag_out <= 1'b1;
    end else if (clear_in) begin
      flag_out <= 1'b0;
    end
  end

endmodule

/* tb.sv */
`timescale 1ns/10ps
module tb;
  logic clk_sys_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic presence_detect_pin_in = 1'b1;
  logic current_fault_in = 1'b0;
  logic voltage_fault_in = 1'b0;
  logic converter_mode_bit_in = 1'b0;
  logic reg_sel_in, reg_wr_in, reg_rd_in;
  logic [7:0] reg_wdata_in, reg_rdata_out, q;
  logic card_present_level_out, converter_enable_out, regulator_mode_out;
  logic supply_1v8_out, supply_3v_out, supply_5v_out, card_deactivate_out;
  logic auto_card_reset_enable_out, shutdown_out, pullup_enable_out;
  int err_count = 0;
  int compares = 0;
  always #5 clk_sys_in = ~clk_sys_in;
  card_status_voltage_regs uut (.*);
  host_model host (.clk_in(clk_sys_in), .rdata_in(reg_rdata_out), .sel_out(reg_sel_in),
    .wr_out(reg_wr_in), .rd_out(reg_rd_in), .wdata_out(reg_wdata_in));
  ////////////////////////////////////////////////////////////////
  task chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
    begin
      compares++;
      if (seen !== exp) begin
        err_count++;
        $display("ERROR %s expected %h seen %h", n, exp, seen);
      end
    end
  endtask
  task give_verdict;
    begin
      $display("Checks %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  function automatic logic [7:0] outs;
    outs = {3'h0, regulator_mode_out, converter_enable_out, supply_1v8_out, supply_3v_out,
      supply_5v_out};
  endfunction
  ////////////////////////////////////////////////////////////////
  task t_reset_vals;
    begin
      host.rd(1'b0, q);
      chk("status_reset", q, 8'h80);
      chk("supply_reset", outs(), 8'h00);
      $display("t_reset_vals done");
    end
  endtask
  task t_sw_flags;
    begin
      host.wr(1'b0, 8'h1C);
      host.rd(1'b0, q);
      chk("flags_set", q, 8'h9C);
      host.wr(1'b0, 8'h1C);
      host.wr(1'b0, 8'h00);
      host.rd(1'b0, q);
      chk("zero_no_clear", q, 8'h9C);
      host.rd(1'b0, q);
      chk("read_clear", q, 8'h80);
      $display("t_sw_flags done");
    end
  endtask
  task t_nocard;
    begin
      host.wr(1'b0, 8'h03);
      chk("conv_nocard", {7'h0, converter_enable_out}, 8'h00);
      host.wr(1'b0, 8'h00);
      $display("t_nocard done");
    end
  endtask
  task t_presence;
    begin
      host.wr(1'b1, 8'h08);
      presence_detect_pin_in = 1'b0;
      repeat (20) @(negedge clk_sys_in);
      chk("present", {7'h0, card_present_level_out}, 8'h01);
      host.rd(1'b0, q);
      chk("insert_flag", q, 8'h90);
      // Four-sample filter must reject a two-cycle glitch
      host.wr(1'b1, 8'h09);
      presence_detect_pin_in = 1'b1;
      repeat (2) @(negedge clk_sys_in);
      presence_detect_pin_in = 1'b0;
      repeat (20) @(negedge clk_sys_in);
      host.rd(1'b0, q);
      chk("glitch_ignored", q, 8'h80);
      $display("t_presence done");
    end
  endtask
  task t_supply;
    begin
      converter_mode_bit_in = 1'b1;
      host.wr(1'b0, 8'h03);
      chk("on_5v", outs(), 8'h09);
      host.wr(1'b0, 8'h01);
      chk("on_1v8", outs(), 8'h1C);
      host.wr(1'b0, 8'h02);
      chk("on_3v", outs(), 8'h0A);
      // Supply dropped before the next nonzero choice
      host.wr(1'b0, 8'h00);
      chk("off", outs(), 8'h00);
      $display("t_supply done");
    end
  endtask
  task t_fault;
    begin
      host.wr(1'b0, 8'h02);
      voltage_fault_in = 1'b1;
      current_fault_in = 1'b1;
      repeat (8) @(negedge clk_sys_in);
      voltage_fault_in = 1'b0;
      current_fault_in = 1'b0;
      host.rd(1'b0, q);
      chk("hw_faults", q, 8'h8E);
      host.wr(1'b0, 8'h00);
      $display("t_fault done");
    end
  endtask
  task t_extract;
    begin
      presence_detect_pin_in = 1'b1;
      repeat (20) @(negedge clk_sys_in);
      host.rd(1'b0, q);
      chk("extract_flag", q, 8'h90);
      $display("t_extract done");
    end
  endtask
  task t_powerup;
    begin
      presence_detect_pin_in = 1'b0;
      reset_n_in = 1'b0;
      repeat (4) @(negedge clk_sys_in);
      reset_n_in = 1'b1;
      // Read before the filter could accept, so only the power-up look sets the flag
      repeat (5) @(negedge clk_sys_in);
      host.rd(1'b0, q);
      chk("powerup_flag", q, 8'h90);
      $display("t_powerup done");
    end
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(negedge clk_sys_in);
    reset_n_in = 1'b1;
    t_reset_vals;
    t_sw_flags;
    t_nocard;
    t_presence;
    t_supply;
    t_fault;
    t_extract;
    t_powerup;
    give_verdict;
  end
  // Whole run needs about 140 cycles
  initial begin
    #20000;
    err_count++;
    give_verdict;
  end
endmodule
